// ---- verilog/tmrc_timer2.sv ----
// Timer2 control register, flags, counters, reloads and interrupt request
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (RQ1) Upper byte wrap sets high overflow flag
// (RQ2) High flag plus enable raises interrupt
// (RQ3) Flags cleared only by software zero writes
// (RQ4) Lower byte wrap sets low flag always
// (RQ5) Low flag interrupts when low enable set
// (RQ6) Capture copies count to reload on fall
// (RQ7) Split select chooses 16-bit or 8+8
// (RQ8) Run gates counting; split gates upper only
// (RQ9) Control bit one reads zero, ignores writes
// (RQ10) Clock is core/12 or external/8 synced
// (RQ11) External select sources both split bytes
// (RQ12) Control at 0xC8, bit addressable, resets zero
// (RQ13) Full wrap loads reload pair into count
// (RQ14) Split halves reload from own bytes
// (RQ15) Capture edge also sets high flag
// (RQ16) Per-byte select forces core clock tick
// (RQ17) Hardware set beats same-cycle software clear
// (RQ18) External clock synchronised, edge makes tick
module tmrc_timer2
  import tmrc_pkg::*;
(
  input wire logic clock, // Core clock, 250 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [7:0] sfr_addr, // Byte access address
  input wire logic sfr_wr, // Byte write strobe
  input wire logic [7:0] sfr_wdata, // Byte write data
  input wire logic sfr_rd, // Byte read strobe
  output logic [7:0] sfr_rdata, // Read data, valid cycle after strobe
  input wire logic sfr_bit_wr, // Single-bit write strobe
  input wire logic [7:0] sfr_bit_addr, // Bit address
  input wire logic sfr_bit_val, // Bit value to write
  input wire logic timer_irq_enable, // Core's timer interrupt enable
  input wire logic high_byte_clock_select, // Upper byte uses core clock in split mode
  input wire logic low_byte_clock_select, // Lower byte uses core clock
  input wire logic ext_osc_div8, // External oscillator divided by 8
  input wire logic lfo_clk, // Low-frequency oscillator output
  output logic timer_irq // Interrupt request level
);
  import tmrc_pkg::*;

  // Two-stage synchronisers plus an edge stage
  logic ext_s1_q, ext_s2_q, ext_s3_q; // External clock chain
  logic lfo_s1_q, lfo_s2_q, lfo_s3_q; // Oscillator chain
  logic ext_tick; // One cycle per external rising edge
  logic lfo_fall; // One cycle per oscillator falling edge
  // Prescaler
  logic [3:0] div_q, div_d; // Divide-by-12 state
  logic div_tick; // One cycle in twelve
  // Control, count and reload state
  logic [7:0] ctrl_q, ctrl_d; // timer2_control
  logic [15:0] cnt_q, cnt_d; // count_high_byte:count_low_byte
  logic [15:0] rl_q, rl_d; // reload_high_byte:reload_low_byte
  logic tick_l, tick_h; // Per-byte count enables
  logic set_h, set_l; // Hardware flag set events
  logic clr_h; // Software clears high flag this cycle
  logic cnt_wr; // Software writes a count byte
  logic rl_wr; // Software writes a reload byte
  // Read and interrupt outputs
  logic [7:0] rdata_q, rdata_d; // Registered read data
  logic irq_q, irq_d; // Registered interrupt level

  // Byte address match, used by every register
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
    addr_hit = (a == t);
  endfunction

  // Synchronisers; the second and third stages feed the edge detect
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      lfo_s1_q <= 1'b0;
      lfo_s2_q <= 1'b0;
      lfo_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_osc_div8;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      lfo_s1_q <= lfo_clk;
      lfo_s2_q <= lfo_s1_q;
      lfo_s3_q <= lfo_s2_q;
    end
  end

  // Edge detect on synchronised levels
  assign ext_tick = ext_s2_q & ~ext_s3_q; // see (RQ18)
  assign lfo_fall = ~lfo_s2_q & lfo_s3_q; // see (RQ6)

  // Core clock divide-by-12 prescaler
  always_comb begin
    div_d = (div_q == TMRC_DIV_LAST) ? 4'h0 : div_q + 4'h1; // see (RQ10)
  end
  assign div_tick = (div_q == TMRC_DIV_LAST);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // Per-byte clock source selection
  always_comb begin
    // Core tick when the byte's own select is set, else the shared source
    tick_l = low_byte_clock_select ? 1'b1
      : (ctrl_q[TMRC_BIT_XCLK] ? ext_tick : div_tick); // see (RQ16) (RQ11)
    tick_h = high_byte_clock_select ? 1'b1
      : (ctrl_q[TMRC_BIT_XCLK] ? ext_tick : div_tick); // see (RQ16) (RQ11)
  end

  // Software write decodes
  assign cnt_wr = sfr_wr
    && (addr_hit(sfr_addr, TMRC_ADDR_CNTL) || addr_hit(sfr_addr, TMRC_ADDR_CNTH));
  assign rl_wr = sfr_wr
    && (addr_hit(sfr_addr, TMRC_ADDR_RLL) || addr_hit(sfr_addr, TMRC_ADDR_RLH));

  // Counting, reload, capture and flag events
  always_comb begin
    cnt_d = cnt_q;
    rl_d = rl_q;
    set_h = 1'b0;
    set_l = 1'b0;
    if (!ctrl_q[TMRC_BIT_SPLIT]) begin
      // Single 16-bit timer on the lower byte's clock
      if (ctrl_q[TMRC_BIT_RUN] && tick_l) begin // see (RQ8) (RQ7)
        if (cnt_q == TMRC_WORD_MAX) begin
          cnt_d = rl_q; // see (RQ13)
          set_h = 1'b1; // see (RQ1)
          set_l = 1'b1; // see (RQ4)
        end else begin
          cnt_d = cnt_q + 16'h0001;
          set_l = (cnt_q[7:0] == TMRC_BYTE_MAX); // see (RQ4)
        end
      end
    end else begin
      // Lower byte always runs in split operation
      if (tick_l) begin // see (RQ8) (RQ7)
        if (cnt_q[7:0] == TMRC_BYTE_MAX) begin
          cnt_d[7:0] = rl_q[7:0]; // see (RQ14)
          set_l = 1'b1; // see (RQ4)
        end else begin
          cnt_d[7:0] = cnt_q[7:0] + 8'h01;
        end
      end
      // Upper byte gated by run control
      if (ctrl_q[TMRC_BIT_RUN] && tick_h) begin // see (RQ8)
        if (cnt_q[15:8] == TMRC_BYTE_MAX) begin
          cnt_d[15:8] = rl_q[15:8]; // see (RQ14)
          set_h = 1'b1; // see (RQ1)
        end else begin
          cnt_d[15:8] = cnt_q[15:8] + 8'h01;
        end
      end
    end
    // Oscillator capture into reload pair
    if (ctrl_q[TMRC_BIT_CEN] && lfo_fall) begin
      rl_d = cnt_q; // see (RQ6)
      set_h = 1'b1; // see (RQ15)
    end
    // Software writes override hardware on data bytes
    if (sfr_wr && addr_hit(sfr_addr, TMRC_ADDR_CNTL)) begin
      cnt_d[7:0] = sfr_wdata;
    end
    if (sfr_wr && addr_hit(sfr_addr, TMRC_ADDR_CNTH)) begin
      cnt_d[15:8] = sfr_wdata;
    end
    if (sfr_wr && addr_hit(sfr_addr, TMRC_ADDR_RLL)) begin
      rl_d[7:0] = sfr_wdata;
    end
    if (sfr_wr && addr_hit(sfr_addr, TMRC_ADDR_RLH)) begin
      rl_d[15:8] = sfr_wdata;
    end
  end

  // Control register: byte and bit writes, then hardware sets
  always_comb begin
    ctrl_d = ctrl_q;
    if (sfr_wr && addr_hit(sfr_addr, TMRC_ADDR_CTRL)) begin // see (RQ12)
      ctrl_d = sfr_wdata & TMRC_CTRL_WMASK; // see (RQ9) (RQ3)
    end
    if (sfr_bit_wr && (sfr_bit_addr[7:3] == TMRC_ADDR_CTRL[7:3])
        && (sfr_bit_addr[2:0] != TMRC_BIT_UNUSED)) begin // see (RQ12) (RQ9)
      ctrl_d[sfr_bit_addr[2:0]] = sfr_bit_val; // see (RQ3)
    end
    // Set after the clear so no overflow is lost
    if (set_h) begin
      ctrl_d[TMRC_BIT_TFH] = 1'b1; // see (RQ17)
    end
    if (set_l) begin
      ctrl_d[TMRC_BIT_TFL] = 1'b1; // see (RQ17)
    end
  end

  // Software clear of the high flag, watched by checks
  assign clr_h = (sfr_wr && addr_hit(sfr_addr, TMRC_ADDR_CTRL) && !sfr_wdata[TMRC_BIT_TFH])
    || (sfr_bit_wr && (sfr_bit_addr[7:3] == TMRC_ADDR_CTRL[7:3])
        && (sfr_bit_addr[2:0] == 3'(TMRC_BIT_TFH)) && !sfr_bit_val);

  // Read mux, registered
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      unique case (sfr_addr)
        TMRC_ADDR_CTRL: rdata_d = ctrl_q; // see (RQ9)
        TMRC_ADDR_RLL: rdata_d = rl_q[7:0];
        TMRC_ADDR_RLH: rdata_d = rl_q[15:8];
        TMRC_ADDR_CNTL: rdata_d = cnt_q[7:0];
        TMRC_ADDR_CNTH: rdata_d = cnt_q[15:8];
        default: rdata_d = TMRC_RD_NONE; // Unmapped address
      endcase
    end
  end

  // Interrupt request from sticky flags
  always_comb begin
    irq_d = timer_irq_enable && (ctrl_q[TMRC_BIT_TFH]
      || (ctrl_q[TMRC_BIT_LEN] && ctrl_q[TMRC_BIT_TFL])); // see (RQ2) (RQ5)
  end

  // State registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= TMRC_CTRL_RST; // see (RQ12)
      cnt_q <= TMRC_CNT_RST;
      rl_q <= TMRC_RL_RST;
      rdata_q <= TMRC_RD_NONE;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      rl_q <= rl_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign timer_irq = irq_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Prescaler spacing of twelve cycles
  sequence s_div_gap;
    ##1 (!div_tick) [*8] ##1 !div_tick ##1 !div_tick ##1 !div_tick ##1 div_tick;
  endsequence
  a_div_twelve: assert property (div_tick |-> s_div_gap) // see (RQ10)
    else $error("prescaler tick spacing is not twelve");

  // Full wrap reloads and flags
  sequence s_full_wrap;
    !ctrl_q[TMRC_BIT_SPLIT] && ctrl_q[TMRC_BIT_RUN] && tick_l
      && cnt_q == TMRC_WORD_MAX && !cnt_wr;
  endsequence
  a_wrap_reload: assert property (s_full_wrap |=> cnt_q == $past(rl_q) // see (RQ13)
      && ctrl_q[TMRC_BIT_TFH] && ctrl_q[TMRC_BIT_TFL]) // see (RQ1)
    else $error("full wrap did not reload or set both flags");

  a_low_wrap: assert property (tick_l && cnt_q[7:0] == TMRC_BYTE_MAX // see (RQ4)
      && (ctrl_q[TMRC_BIT_SPLIT] || ctrl_q[TMRC_BIT_RUN]) |=> ctrl_q[TMRC_BIT_TFL])
    else $error("low byte wrap did not set low flag");

  a_flag_sticky: assert property (ctrl_q[TMRC_BIT_TFH] && !clr_h // see (RQ3)
      |=> ctrl_q[TMRC_BIT_TFH])
    else $error("high flag cleared without software");

  a_set_wins: assert property (set_h && clr_h |=> ctrl_q[TMRC_BIT_TFH]) // see (RQ17)
    else $error("same-cycle clear beat hardware set");

  a_irq_high: assert property (timer_irq_enable && ctrl_q[TMRC_BIT_TFH] // see (RQ2)
      |=> timer_irq)
    else $error("high flag did not raise interrupt");

  a_irq_low: assert property (timer_irq_enable && !ctrl_q[TMRC_BIT_TFH] // see (RQ5)
      |=> timer_irq == $past(ctrl_q[TMRC_BIT_LEN] && ctrl_q[TMRC_BIT_TFL]))
    else $error("low flag interrupt gating wrong");

  a_capture_copy: assert property (ctrl_q[TMRC_BIT_CEN] && lfo_fall && !rl_wr // see (RQ6)
      |=> rl_q == $past(cnt_q) && ctrl_q[TMRC_BIT_TFH]) // see (RQ15)
    else $error("capture edge did not copy count");

  a_run_stopped: assert property (!ctrl_q[TMRC_BIT_SPLIT] && !ctrl_q[TMRC_BIT_RUN] // see (RQ8)
      && !cnt_wr |=> $stable(cnt_q))
    else $error("stopped 16-bit timer counted");

  a_split_low_runs: assert property (ctrl_q[TMRC_BIT_SPLIT] && tick_l && !cnt_wr // see (RQ7)
      |=> cnt_q[7:0] != $past(cnt_q[7:0]) || $past(rl_q[7:0]) == TMRC_BYTE_MAX)
    else $error("split low byte did not advance");

  a_unused_zero: assert property (ctrl_q[TMRC_BIT_UNUSED] == 1'b0) // see (RQ9)
    else $error("unused control bit is set");

endmodule : tmrc_timer2

`default_nettype wire

// ---- verilog/tmrc_pkg.sv ----
// Constants for the timer2 control, flag and counting block
package tmrc_pkg;
  // Special-function-space addresses
  localparam logic [7:0] TMRC_ADDR_CTRL = 8'hC8; // timer2_control
  localparam logic [7:0] TMRC_ADDR_RLL = 8'hCA; // reload_low_byte
  localparam logic [7:0] TMRC_ADDR_RLH = 8'hCB; // reload_high_byte
  localparam logic [7:0] TMRC_ADDR_CNTL = 8'hCC; // count_low_byte
  localparam logic [7:0] TMRC_ADDR_CNTH = 8'hCD; // count_high_byte
  // Bit positions inside timer2_control
  localparam int unsigned TMRC_BIT_TFH = 7; // high_overflow_flag
  localparam int unsigned TMRC_BIT_TFL = 6; // low_overflow_flag
  localparam int unsigned TMRC_BIT_LEN = 5; // low_byte_irq_enable
  localparam int unsigned TMRC_BIT_CEN = 4; // lfo_capture_enable
  localparam int unsigned TMRC_BIT_SPLIT = 3; // split_mode_select
  localparam int unsigned TMRC_BIT_RUN = 2; // run_control
  localparam logic [2:0] TMRC_BIT_UNUSED = 3'h1; // always reads zero
  localparam int unsigned TMRC_BIT_XCLK = 0; // ext_clock_select
  // Reset values and masks
  localparam logic [7:0] TMRC_CTRL_RST = 8'h00; // Control reset value
  localparam logic [7:0] TMRC_CTRL_WMASK = 8'hFD; // Writable control bits
  localparam logic [15:0] TMRC_CNT_RST = 16'h0000; // Count reset value
  localparam logic [15:0] TMRC_RL_RST = 16'h0000; // Reload reset value
  localparam logic [7:0] TMRC_RD_NONE = 8'h00; // Unmapped read value
  localparam logic [7:0] TMRC_BYTE_MAX = 8'hFF; // Byte rollover point
  localparam logic [15:0] TMRC_WORD_MAX = 16'hFFFF; // Word rollover point
  // Timing counts
  localparam int unsigned TMRC_CORE_DIV = 12; // Core clock prescale
  localparam logic [3:0] TMRC_DIV_LAST = 4'hB; // Last prescaler state
endpackage : tmrc_pkg

// ---- testbench/tb_tmrc_timer2.sv ----
// Self-checking bench for the timer2 control, flag and counting block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_tmrc_timer2;
  import tmrc_pkg::*;
  logic clock = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0, sfr_bit_val = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata;
  logic timer_irq_enable = 0, high_byte_clock_select = 0, low_byte_clock_select = 0;
  logic ext_osc_div8 = 0, lfo_clk = 0, timer_irq;
  int fails = 0, checks_done = 0;
  always #2 clock = ~clock; // 250 MHz
  tmrc_timer2 DUT (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val),
    .timer_irq_enable(timer_irq_enable), .high_byte_clock_select(high_byte_clock_select),
    .low_byte_clock_select(low_byte_clock_select), .ext_osc_div8(ext_osc_div8),
    .lfo_clk(lfo_clk), .timer_irq(timer_irq));
  // Byte write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock); #1 sfr_addr = a; sfr_wdata = d; sfr_wr = 1;
    @(posedge clock); #1 sfr_wr = 0;
  endtask
  // Single-bit write
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clock); #1 sfr_bit_addr = a; sfr_bit_val = v; sfr_bit_wr = 1;
    @(posedge clock); #1 sfr_bit_wr = 0;
  endtask
  // Read strobe; data settles one cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge clock); #1 sfr_addr = a; sfr_rd = 1;
    @(posedge clock); #1 sfr_rd = 0;
  endtask
  // Read and compare against an expected byte
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(sfr_rdata, e)
  endtask
  // External divided clock pulses, each rising edge one tick
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock); #1 ext_osc_div8 = 1; repeat (4) @(posedge clock);
      #1 ext_osc_div8 = 0; repeat (4) @(posedge clock);
    end
  endtask
  // Reset values, unused bit, bit addressing, unmapped read
  task automatic t_regs;
    rdc(TMRC_ADDR_CTRL, 8'h00);
    rdc(TMRC_ADDR_CNTH, 8'h00);
    rdc(8'hC9, 8'h00);
    wr(TMRC_ADDR_CTRL, 8'h02); rdc(TMRC_ADDR_CTRL, 8'h00);
    bw(8'hC9, 1'b1); rdc(TMRC_ADDR_CTRL, 8'h00);
    bw(8'hCB, 1'b1); rdc(TMRC_ADDR_CTRL, 8'h08);
    wr(TMRC_ADDR_CTRL, 8'h00);
    $display("test regs done");
  endtask
  // 16-bit wrap on external ticks, reload, flags, interrupt
  task automatic t_wrap16;
    wr(TMRC_ADDR_CNTL, 8'hFE); wr(TMRC_ADDR_CNTH, 8'hFF);
    wr(TMRC_ADDR_RLL, 8'h34); wr(TMRC_ADDR_RLH, 8'h12);
    wr(TMRC_ADDR_CTRL, 8'h05); tick(1);
    rdc(TMRC_ADDR_CTRL, 8'h05);
    rdc(TMRC_ADDR_CNTL, 8'hFF);
    tick(1); rdc(TMRC_ADDR_CNTL, 8'h34);
    rdc(TMRC_ADDR_CNTH, 8'h12);
    rdc(TMRC_ADDR_CTRL, 8'hC5);
    `CHK(timer_irq, 1'b0)
    timer_irq_enable = 1; repeat (3) @(posedge clock); #1;
    `CHK(timer_irq, 1'b1)
    repeat (50) @(posedge clock); rdc(TMRC_ADDR_CTRL, 8'hC5);
    wr(TMRC_ADDR_CTRL, 8'h05); repeat (2) @(posedge clock); #1;
    `CHK(timer_irq, 1'b0)
    // Low byte wrap only
    wr(TMRC_ADDR_CNTL, 8'hFF); wr(TMRC_ADDR_CNTH, 8'h00); tick(1);
    rdc(TMRC_ADDR_CTRL, 8'h45);
    rdc(TMRC_ADDR_CNTH, 8'h01);
    `CHK(timer_irq, 1'b0)
    bw(8'hCD, 1'b1); repeat (2) @(posedge clock); #1;
    `CHK(timer_irq, 1'b1)
    timer_irq_enable = 0; wr(TMRC_ADDR_CTRL, 8'h00);
    $display("test wrap16 done");
  endtask
  // Split mode, run gates upper byte only, own reload bytes
  task automatic t_split;
    wr(TMRC_ADDR_RLL, 8'h80); wr(TMRC_ADDR_RLH, 8'h90);
    wr(TMRC_ADDR_CNTL, 8'hFF); wr(TMRC_ADDR_CNTH, 8'h05);
    wr(TMRC_ADDR_CTRL, 8'h09); tick(1);
    rdc(TMRC_ADDR_CNTL, 8'h80);
    rdc(TMRC_ADDR_CNTH, 8'h05);
    rdc(TMRC_ADDR_CTRL, 8'h49);
    bw(8'hCA, 1'b1); wr(TMRC_ADDR_CNTH, 8'hFF); tick(1);
    rdc(TMRC_ADDR_CNTH, 8'h90);
    rdc(TMRC_ADDR_CNTL, 8'h81);
    rdc(TMRC_ADDR_CTRL, 8'hCD);
    // Upper byte on core clock, lower byte waits for external ticks
    wr(TMRC_ADDR_CTRL, 8'h00); high_byte_clock_select = 1;
    wr(TMRC_ADDR_CNTL, 8'h10); wr(TMRC_ADDR_CNTH, 8'h00);
    wr(TMRC_ADDR_CTRL, 8'h0D); repeat (20) @(posedge clock);
    wr(TMRC_ADDR_CTRL, 8'h09);
    rdc(TMRC_ADDR_CNTH, 8'h16);
    rdc(TMRC_ADDR_CNTL, 8'h10);
    high_byte_clock_select = 0; wr(TMRC_ADDR_CTRL, 8'h00);
    $display("test split done");
  endtask
  // Core clock divided by 12, then per-byte core clock select
  task automatic t_prescale;
    wr(TMRC_ADDR_CNTL, 8'h00); wr(TMRC_ADDR_CNTH, 8'h00);
    wr(TMRC_ADDR_CTRL, 8'h04); repeat (120) @(posedge clock);
    wr(TMRC_ADDR_CTRL, 8'h00); rd(TMRC_ADDR_CNTL);
    `CHK(sfr_rdata >= 8'h0A && sfr_rdata <= 8'h0B, 1'b1)
    low_byte_clock_select = 1; wr(TMRC_ADDR_CNTL, 8'h00);
    wr(TMRC_ADDR_CTRL, 8'h05); repeat (20) @(posedge clock);
    wr(TMRC_ADDR_CTRL, 8'h01);
    rdc(TMRC_ADDR_CNTL, 8'h16);
    low_byte_clock_select = 0; wr(TMRC_ADDR_CTRL, 8'h00);
    $display("test prescale done");
  endtask
  // Oscillator capture copies count into reload and sets high flag
  task automatic t_capture;
    wr(TMRC_ADDR_CNTL, 8'h21); wr(TMRC_ADDR_CNTH, 8'h43);
    timer_irq_enable = 1; wr(TMRC_ADDR_CTRL, 8'h10);
    @(posedge clock); #1 lfo_clk = 1; repeat (6) @(posedge clock);
    #1 lfo_clk = 0; repeat (6) @(posedge clock);
    rdc(TMRC_ADDR_RLL, 8'h21);
    rdc(TMRC_ADDR_RLH, 8'h43);
    rdc(TMRC_ADDR_CTRL, 8'h90);
    `CHK(timer_irq, 1'b1)
    timer_irq_enable = 0;
    $display("test capture done");
  endtask
  // Wrap and software flag clear in one cycle, then reset in mid-run
  task automatic t_race;
    low_byte_clock_select = 1; wr(TMRC_ADDR_CTRL, 8'h00);
    wr(TMRC_ADDR_CNTL, 8'hFF); wr(TMRC_ADDR_CNTH, 8'hFF);
    // Two back-to-back writes: start, then clear flags at the wrap
    @(posedge clock); #1 sfr_addr = TMRC_ADDR_CTRL; sfr_wdata = 8'h04; sfr_wr = 1;
    repeat (2) @(posedge clock);
    #1 sfr_wr = 0;
    rdc(TMRC_ADDR_CTRL, 8'hC4);
    rdc(TMRC_ADDR_CNTH, 8'h43);
    @(posedge clock); #1 sys_rst = 1;
    @(posedge clock); #1 sys_rst = 0;
    rdc(TMRC_ADDR_CTRL, 8'h00);
    rdc(TMRC_ADDR_RLH, 8'h00);
    low_byte_clock_select = 0;
    $display("test race done");
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #40000;
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    #1 sys_rst = 0;
    t_regs();
    t_wrap16();
    t_split();
    t_prescale();
    t_capture();
    t_race();
    conclude();
  end
endmodule // tb_tmrc_timer2
`default_nettype wire
